//--- bench/twm_master_assertions.sv
// checker for the two-wire master register port and link drive
module twm_master_assertions
   import twm_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        irq,
   // link drive
   input wire logic        scl_oe,
   input wire logic        sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire st_rd  = reg_rd && reg_addr == OFS_STAT;
   wire dis_wr = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_MDIS_BIT];
   wire mk_off = reg_wr && reg_addr == OFS_MASK && reg_wdata[4:0] == 5'h00;
   // two edges of slack: the write edge and the data hold stage may still move the pins
   freeze_pins_a: assert property (dis_wr |=> ##2 ($stable(scl_oe) && $stable(sda_oe))[*8])
      else $error("link pins moved after disable");
   nack_pair_a: assert property (st_rd |=> (!reg_rdata[3] || reg_rdata[0]))
      else $error("nack seen without transfer complete");
   nack_clear_a: assert property (st_rd ##1 reg_rdata[3] ##[1:4] st_rd |=> !reg_rdata[3])
      else $error("nack survived a status read");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   irq_mask_a: assert property (mk_off |=> ##1 !irq)
      else $error("interrupt high with mask cleared");
endmodule

bind twm_master twm_master_assertions chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .scl_oe(scl_oe), .sda_oe(sda_oe));

//--- bench/twm_master_tb_top.sv
// self-checking bench for the two-wire master
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module twm_master_tb_top
   import twm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] d;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        nack_mode = 1'b0;
   logic        slow = 1'b0;
   wire  [31:0] reg_rdata;
   wire  [7:0]  rx_byte;
   wire         irq, scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
   int          num_errors = 0;
   int          checks_done = 0;
   wire         scl_line = !scl_oe && !scl_pull;
   wire         sda_line = !sda_oe && !sda_pull;
   always #12.5 core_clk = ~core_clk;
   twm_master uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_i(scl_line),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
   twm_slave_model #(.ADDR(7'h2a)) slave (.scl(scl_line), .sda(sda_line), .nack_mode(nack_mode),
      .slow(slow), .rd_base(8'h3c), .scl_pull(scl_pull), .sda_pull(sda_pull), .rx_byte(rx_byte));
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   // interrupt wait instead of status polling during a frame
   task automatic wait_irq();
      int k;
      repeat (4) @(posedge core_clk);
      for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge core_clk);
      if (k == 4000) begin num_errors++; test_done(); end
   endtask
   task automatic scl_rises(input int n);
      int   k;
      logic p;
      p = scl_line;
      for (k = 0; k < 20000 && n > 0; k++) begin
         @(posedge core_clk);
         if (scl_line && !p) n--;
         p = scl_line;
      end
      if (n > 0) begin num_errors++; test_done(); end
   endtask
   task automatic go(input logic rdf);
      wr(OFS_MODE, (32'(7'h2a) << MODE_DADR_LSB) | (32'(rdf) << MODE_READ_BIT));
      wr(OFS_CTRL, 32'h1 << CTRL_START_BIT);
   endtask
   task automatic s_reset();
      rd(OFS_STAT);
      `CHK("reset status", 5'b00101, d[4:0])
      rd(8'hfc);
      `CHK("unmapped", 32'h0, d)
      `CHK("drive levels", 2'b00, {scl_o, sda_o})
      // low four cycles, high two plus sync: a 200 ns link clock
      wr(OFS_WAVE, 32'h0000_0204);
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTRL, 32'h1 << CTRL_MEN_BIT);
      `CHK("irq raised", 1'b1, irq)
   endtask
   task automatic s_nack();
      nack_mode <= 1'b1;
      go(1'b0);
      wait_irq();
      rd(OFS_STAT);
      `CHK("nack status", 5'b01101, d[4:0])
      rd(OFS_STAT);
      `CHK("nack cleared", 5'b00101, d[4:0])
   endtask
   task automatic s_lost();
      int k;
      go(1'b0);
      scl_rises(9);
      for (k = 0; k < 100 && scl_line; k++) @(posedge core_clk);
      if (k == 100) begin num_errors++; test_done(); end
      rd(OFS_STAT);
      `CHK("mid frame", 5'b00100, d[4:0])
      wait_irq();
      rd(OFS_STAT);
      `CHK("nack lost", 5'b00101, d[4:0])
      nack_mode <= 1'b0;
   endtask
   task automatic s_read();
      slow <= 1'b1;
      go(1'b1);
      scl_rises(19);
      wr(OFS_CTRL, 32'h1 << CTRL_STOP_BIT);
      wait_irq();
      rd(OFS_STAT);
      `CHK("no overrun", 5'b00111, d[4:0])
      rd(OFS_RHR);
      `CHK("last byte", 8'h3d, d[7:0])
      slow <= 1'b0;
   endtask
   task automatic s_write();
      wr(OFS_THR, 32'ha5);
      go(1'b0);
      wait_irq();
      `CHK("line byte", 8'ha5, rx_byte)
      rd(OFS_STAT);
      `CHK("tx flags", 5'b00101, d[4:0])
      rd(OFS_RHR);
      `CHK("rhr tx byte", 8'ha5, d[7:0])
   endtask
   task automatic s_disable();
      logic [1:0] pins;
      // transmit_ready_flag is still set from the last frame, so a disable that cleared it shows
      go(1'b0);
      scl_rises(3);
      wr(OFS_MASK, 32'h0);
      wr(OFS_CTRL, 32'h1 << CTRL_MDIS_BIT);
      repeat (3) @(posedge core_clk);
      pins = {scl_oe, sda_oe};
      repeat (60) @(posedge core_clk);
      `CHK("frozen pins", pins, {scl_oe, sda_oe})
      rd(OFS_STAT);
      `CHK("kept flags", 5'b00100, d[4:0])
      `CHK("irq masked", 1'b0, irq)
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      s_reset();
      s_nack();
      s_lost();
      s_read();
      s_write();
      s_disable();
      test_done();
   end
endmodule

//--- bench/twm_slave_model.sv
// behavioural two-wire slave: acks, read data, clock stretching
module twm_slave_model
   import twm_pkg::*;
#(
   parameter logic [6:0] ADDR = 7'h2a
)
(
   // line levels
   input  wire logic       scl,
   input  wire logic       sda,
   // scenario controls
   input  wire logic       nack_mode,
   input  wire logic       slow,
   input  wire logic [7:0] rd_base,
   // open-drain pulls and last written byte
   output logic            scl_pull,
   output logic            sda_pull,
   output logic [7:0]      rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   int         bitn = -1;
   int         nb = 0;
   logic       adr_ph = 1'b0;
   logic       rd = 1'b0;
   logic       hit = 1'b0;
   logic       mack = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = 8'h00;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      rx_byte  = 8'h00;
   end
   // start and stop only count while the clock line is high
   always @(negedge sda) if (scl) begin
      bitn   = 0;
      nb     = 0;
      adr_ph = 1'b1;
   end
   always @(posedge sda) if (scl) begin
      bitn     = -1;
      sda_pull = 1'b0;
   end
   always @(posedge scl) if (bitn >= 0) begin
      if (bitn < 8) sh = {sh[6:0], sda};
      if (bitn == 8) mack = !sda;
      bitn = bitn + 1;
   end
   always @(negedge scl) if (bitn >= 0) begin
      if (bitn == 8) begin
         if (adr_ph) begin
            rd  = sh[0];
            hit = sh[7:1] == ADDR;
         end else if (!rd) rx_byte = sh;
         sda_pull = hit && !nack_mode && !(rd && !adr_ph);
      end else if (bitn == 9) begin
         bitn   = 0;
         adr_ph = 1'b0;
         tx     = rd_base + 8'(nb);
         nb     = nb + 1;
         // a refused byte means the master wants the bus back for stop
         sda_pull = hit && rd && mack && !tx[7];
      end else sda_pull = hit && rd && !adr_ph && mack && !tx[7-bitn];
      if (slow) begin
         scl_pull = 1'b1;
         #300;
         scl_pull = 1'b0;
      end
   end
endmodule

//--- inc/twm_pkg.sv
// package for the two-wire master: register map, fields, states and carriers
package twm_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_WAVE = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h20;
   localparam logic [7:0] OFS_MASK = 8'h24;
   localparam logic [7:0] OFS_RHR  = 8'h30;
   localparam logic [7:0] OFS_THR  = 8'h34;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT  = 1;
   localparam int CTRL_MEN_BIT   = 2;
   localparam int CTRL_MDIS_BIT  = 3;
   localparam int MODE_READ_BIT  = 12;
   localparam int MODE_DADR_LSB  = 16;
   localparam int WAVE_HDIV_LSB  = 8;
   localparam int WAVE_EXP_LSB   = 16;
   // ---------------------------------------------------------------
   // widths, counts and reset values
   // ---------------------------------------------------------------
   localparam int PER_W = 13;
   localparam logic [3:0]       LAST_DATA_BIT = 4'h7;
   localparam logic [3:0]       ACK_BIT       = 4'h8;
   localparam logic [PER_W-1:0] PER_MIN       = 13'h0001;
   localparam logic [6:0]       DADR_RST      = 7'h00;
   localparam logic [7:0]       BYTE_RST      = 8'h00;
   localparam logic [31:0]      WORD_RST      = 32'h0000_0000;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic overrun_flag;
      logic nack;
      logic transmit_ready_flag;
      logic receive_ready_flag;
      logic transfer_complete_flag;
   } twm_stat_t;
   localparam twm_stat_t STAT_RST = '{overrun_flag: 1'b0, nack: 1'b0, transmit_ready_flag: 1'b1, receive_ready_flag: 1'b0, transfer_complete_flag: 1'b1};
   typedef struct packed {
      logic [2:0] dexp;
      logic [7:0] hdiv;
      logic [7:0] ldiv;
   } twm_wave_t;
   localparam twm_wave_t WAVE_RST = '{dexp: 3'h0, hdiv: 8'h00, ldiv: 8'h00};
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} twm_state_t;
endpackage

//--- src/twm_master.sv
// two-wire master controller with status flags, receive holding register and interrupt
// Operation
// - writing the master-disable bit freezes a transfer one engine step later and leaves transfer-complete and transmit-ready as they are.
// - transfer-complete and not-acknowledge are set in the same cycle, and a status read clears not-acknowledge.
// - a status read between a not-acknowledge and transfer-complete cancels the not-acknowledge flag.
// - a byte received after a stop command while receive-ready is still set does not raise overrun.
// - every finished data byte loads the receive holding register, the address byte does not, and a transmit byte sets neither receive-ready nor overrun.
module twm_master
   import twm_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // interrupt
   output logic             irq,
   // open-drain link
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic             scl_meta_ff, scl_sync_ff, sda_meta_ff, sda_sync_ff;
   logic             enable_ff, mread_ff, stop_req_ff, addr_phase_ff, nack_pend_ff, irq_ff;
   logic [6:0]       dadr_ff;
   twm_wave_t        wave_ff;
   twm_stat_t        stat_ff, mask_ff, nxt_stat;
   logic [7:0]       rhr_ff, thr_ff, sh_ff, nxt_rhr, nxt_sh;
   logic [31:0]      rdata_ff;
   twm_state_t       state_ff, nxt_state;
   logic [1:0]       sub_ff, nxt_sub;
   logic [3:0]       bit_ff, nxt_bit;
   logic [PER_W-1:0] cnt_ff, nxt_cnt;
   logic             scl_drv_ff, sda_drv_ff, nxt_scl_drv, nxt_sda_drv;
   logic             sda_oe_ff;
   logic             nxt_stop_req, nxt_addr_phase, nxt_nack_pend;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // products above 13 bits wrap; the divider itself cannot hold more
   function automatic logic [PER_W-1:0] fn_period(input logic [7:0] div, input logic [2:0] dexp);
      logic [15:0] prod;
      prod = {8'h00, div} << dexp;
      if (prod[PER_W-1:0] == '0) begin
         return PER_MIN;
      end
      return prod[PER_W-1:0];
   endfunction

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   wire              wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
   wire              wr_mode  = reg_wr && (reg_addr == OFS_MODE);
   wire              wr_wave  = reg_wr && (reg_addr == OFS_WAVE);
   wire              wr_stat  = reg_wr && (reg_addr == OFS_STAT);
   wire              wr_mask  = reg_wr && (reg_addr == OFS_MASK);
   wire              wr_thr   = reg_wr && (reg_addr == OFS_THR);
   wire              rd_stat  = reg_rd && (reg_addr == OFS_STAT);
   wire              rd_rhr   = reg_rd && (reg_addr == OFS_RHR);
   wire              cmd_start = wr_ctrl && reg_wdata[CTRL_START_BIT];
   wire              cmd_stop  = wr_ctrl && reg_wdata[CTRL_STOP_BIT];
   wire              cmd_men   = wr_ctrl && reg_wdata[CTRL_MEN_BIT];
   wire              cmd_mdis  = wr_ctrl && reg_wdata[CTRL_MDIS_BIT];
   wire twm_stat_t   w1c      = wr_stat ? twm_stat_t'(reg_wdata[4:0]) : '0;
   wire [PER_W-1:0]  lo_per   = fn_period(wave_ff.ldiv, wave_ff.dexp);
   wire [PER_W-1:0]  hi_per   = fn_period(wave_ff.hdiv, wave_ff.dexp);
   wire              tick     = (cnt_ff <= PER_MIN);
   wire              rx_byte  = !addr_phase_ff && mread_ff;
   wire [7:0]        sh_next  = {sh_ff[6:0], sda_sync_ff};
   wire [31:0]       rd_mux   = (reg_addr == OFS_MODE) ? {9'h000, dadr_ff, 3'h0, mread_ff, 12'h000} :
                                (reg_addr == OFS_WAVE) ? {13'h0000, wave_ff} :
                                (reg_addr == OFS_STAT) ? {27'h0000000, stat_ff} :
                                (reg_addr == OFS_MASK) ? {27'h0000000, mask_ff} :
                                (reg_addr == OFS_RHR)  ? {24'h000000, rhr_ff} : WORD_RST;

   // ---------------------------------------------------------------
   // transfer engine
   // ---------------------------------------------------------------
   always_comb begin
      twm_stat_t set_f;
      twm_stat_t clr_f;
      logic      nack_set;
      set_f          = '0;
      clr_f          = w1c;
      nack_set       = 1'b0;
      nxt_state      = state_ff;
      nxt_sub        = sub_ff;
      nxt_bit        = bit_ff;
      nxt_cnt        = cnt_ff;
      nxt_sh         = sh_ff;
      nxt_rhr        = rhr_ff;
      nxt_scl_drv    = scl_drv_ff;
      nxt_sda_drv    = sda_drv_ff;
      nxt_addr_phase = addr_phase_ff;
      nxt_stop_req   = stop_req_ff || cmd_stop;
      // a frozen engine holds every step and every flag it owns
      if (enable_ff) begin
         nxt_cnt = tick ? cnt_ff : cnt_ff - PER_MIN;
         unique case (state_ff)
            ST_IDLE: begin
               nxt_stop_req = 1'b0;
               if (cmd_start) begin
                  nxt_state      = ST_START;
                  nxt_sh         = {dadr_ff, mread_ff};
                  nxt_addr_phase = 1'b1;
                  nxt_sda_drv    = 1'b1;
                  nxt_cnt        = hi_per;
                  clr_f.transfer_complete_flag   = 1'b1;
               end
            end
            ST_START: begin
               if (tick) begin
                  nxt_state   = ST_BITS;
                  nxt_sub     = 2'd0;
                  nxt_bit     = 4'h0;
                  nxt_scl_drv = 1'b1;
                  nxt_sda_drv = !sh_ff[7];
                  nxt_cnt     = lo_per;
               end
            end
            ST_BITS: begin
               if (sub_ff == 2'd0) begin
                  if (tick) begin
                     nxt_sub     = 2'd1;
                     nxt_scl_drv = 1'b0;
                     nxt_cnt     = hi_per;
                  end
               end else begin
                  // a slave holding the clock low stretches the high phase
                  nxt_cnt = (tick || !scl_sync_ff) ? cnt_ff : cnt_ff - PER_MIN;
                  if (tick && scl_sync_ff) begin
                     nxt_sub     = 2'd0;
                     nxt_scl_drv = 1'b1;
                     nxt_cnt     = lo_per;
                     if (bit_ff != ACK_BIT) begin
                        nxt_sh  = sh_next;
                        nxt_bit = bit_ff + 4'h1;
                        nxt_sda_drv = !mread_ff && !addr_phase_ff ? !sh_ff[6] : addr_phase_ff && !sh_ff[6];
                        if (bit_ff == LAST_DATA_BIT) begin
                           nxt_sda_drv = rx_byte && !stop_req_ff;
                           if (!addr_phase_ff) begin
                              nxt_rhr = sh_next;
                           end
                           if (rx_byte) begin
                              set_f.receive_ready_flag = 1'b1;
                              set_f.overrun_flag  = stat_ff.receive_ready_flag && !stop_req_ff;
                           end
                        end
                     end else if (!rx_byte && sda_sync_ff) begin
                        nack_set    = 1'b1;
                        nxt_state   = ST_STOP;
                        nxt_sda_drv = 1'b1;
                     end else if (rx_byte && stop_req_ff) begin
                        nxt_state   = ST_STOP;
                        nxt_sda_drv = 1'b1;
                     end else if (mread_ff) begin
                        nxt_addr_phase = 1'b0;
                        nxt_bit        = 4'h0;
                        nxt_sda_drv    = 1'b0;
                     end else if (!stat_ff.transmit_ready_flag) begin
                        nxt_addr_phase = 1'b0;
                        nxt_bit        = 4'h0;
                        nxt_sh         = thr_ff;
                        nxt_sda_drv    = !thr_ff[7];
                        set_f.transmit_ready_flag    = 1'b1;
                     end else begin
                        nxt_state   = ST_STOP;
                        nxt_sda_drv = 1'b1;
                     end
                  end
               end
            end
            ST_STOP: begin
               if (tick && sub_ff == 2'd0) begin
                  nxt_sub     = 2'd1;
                  nxt_scl_drv = 1'b0;
                  nxt_cnt     = hi_per;
               end else if (tick && sub_ff == 2'd1 && scl_sync_ff) begin
                  nxt_sub     = 2'd2;
                  nxt_sda_drv = 1'b0;
                  nxt_cnt     = hi_per;
               end else if (tick && sub_ff == 2'd2) begin
                  nxt_state    = ST_IDLE;
                  nxt_sub      = 2'd0;
                  set_f.transfer_complete_flag = 1'b1;
                  set_f.nack   = nack_pend_ff;
               end
            end
         endcase
      end
      // reading status drops the flag and any detection still pending
      clr_f.nack    = clr_f.nack || rd_stat;
      nxt_nack_pend = nack_set || (nack_pend_ff && !rd_stat && !set_f.nack);
      clr_f.receive_ready_flag   = clr_f.receive_ready_flag || rd_rhr;
      clr_f.transmit_ready_flag   = wr_thr;
      nxt_stat      = (stat_ff & ~clr_f) | set_f;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_meta_ff, scl_sync_ff, sda_meta_ff, sda_sync_ff} <= 4'hf;
      end else begin
         {scl_meta_ff, scl_sync_ff, sda_meta_ff, sda_sync_ff} <= {scl_i, scl_meta_ff, sda_i, sda_meta_ff};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_ff <= 1'b0;
         mread_ff  <= 1'b0;
         dadr_ff   <= DADR_RST;
         wave_ff   <= WAVE_RST;
         mask_ff   <= '0;
         thr_ff    <= BYTE_RST;
         rdata_ff  <= WORD_RST;
      end else begin
         enable_ff <= (enable_ff || cmd_men) && !cmd_mdis;
         mread_ff  <= wr_mode ? reg_wdata[MODE_READ_BIT] : mread_ff;
         dadr_ff   <= wr_mode ? reg_wdata[MODE_DADR_LSB +: 7] : dadr_ff;
         wave_ff   <= wr_wave ? twm_wave_t'(reg_wdata[WAVE_EXP_LSB+2:0]) : wave_ff;
         mask_ff   <= wr_mask ? twm_stat_t'(reg_wdata[4:0]) : mask_ff;
         thr_ff    <= wr_thr ? reg_wdata[7:0] : thr_ff;
         rdata_ff  <= reg_rd ? rd_mux : WORD_RST;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff      <= ST_IDLE;
         sub_ff        <= 2'd0;
         bit_ff        <= 4'h0;
         cnt_ff        <= PER_MIN;
         sh_ff         <= BYTE_RST;
         rhr_ff        <= BYTE_RST;
         scl_drv_ff    <= 1'b0;
         sda_drv_ff    <= 1'b0;
         sda_oe_ff     <= 1'b0;
         addr_phase_ff <= 1'b0;
         stop_req_ff   <= 1'b0;
         nack_pend_ff  <= 1'b0;
         stat_ff       <= STAT_RST;
         irq_ff        <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         sub_ff        <= nxt_sub;
         bit_ff        <= nxt_bit;
         cnt_ff        <= nxt_cnt;
         sh_ff         <= nxt_sh;
         rhr_ff        <= nxt_rhr;
         scl_drv_ff    <= nxt_scl_drv;
         sda_drv_ff    <= nxt_sda_drv;
         sda_oe_ff     <= sda_drv_ff;
         addr_phase_ff <= nxt_addr_phase;
         stop_req_ff   <= nxt_stop_req;
         nack_pend_ff  <= nxt_nack_pend;
         stat_ff       <= nxt_stat;
         irq_ff        <= |(nxt_stat & mask_ff);
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // open drain: the pins are only ever pulled low
   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign scl_oe    = scl_drv_ff;
   // data lags the clock line by one cycle: no data edge while the clock falls
   assign sda_oe    = sda_oe_ff;
   assign reg_rdata = rdata_ff;
   assign irq       = irq_ff;
endmodule
